// ---- pkg/gect_regs.svh ----
// register offsets, field positions and reset values of the gated counter/timer
// assumes a 12-bit byte address on the apb side, one word per register
`ifndef GECT_REGS_SVH
`define GECT_REGS_SVH

`define GECT_CTRL_OFF    12'h000
`define GECT_RELOAD_OFF  12'h004
`define GECT_COUNT_OFF   12'h008
`define GECT_STATUS_OFF  12'h00C
`define GECT_CLR_OFF     12'h010
`define GECT_INTEN_OFF   12'h014

`define GECT_EN_B        0
`define GECT_MODE_B      1
`define GECT_DIR_B       2
`define GECT_RLD_B       3
`define GECT_OUTEN_B     4
`define GECT_SRC_B       5
`define GECT_EDGE_LO     6
`define GECT_EDGE_HI     7
`define GECT_TRST_B      8

`define GECT_CNT_W       16
`define GECT_CNT_MAX     16'hFFFF
`define GECT_CNT_ZERO    16'h0000
`define GECT_RELOAD_RST  16'hFFFF

`endif

// ---- pkg/gect_pkg.sv ----
// types of the gated counter/timer
// assumes gect_regs.svh sits on the include path
`include "gect_regs.svh"

package gect_pkg;

  // edge qualifier: bit 0 rising, bit 1 falling
  typedef enum logic [1:0] {
    GECT_EDGE_NONE = 2'h0,
    GECT_EDGE_RISE = 2'h1,
    GECT_EDGE_FALL = 2'h2,
    GECT_EDGE_BOTH = 2'h3
  } gect_edge_t;

  typedef struct packed {
    logic [2:0]             pin_sync;
    logic                   pin_q;
    logic                   prev_q;
    logic                   en;
    logic                   mode;
    logic                   dir;
    logic                   rld;
    logic                   outen;
    logic                   src;
    gect_edge_t             edge_sel;
    logic [`GECT_CNT_W-1:0] cnt;
    logic [`GECT_CNT_W-1:0] reload;
    logic [1:0]             status;
    logic [1:0]             inten;
    logic                   tout;
    logic                   ovf;
    logic                   irq;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } gect_state_t;

endpackage

// ---- src/gect_timer.sv ----
// one 16-bit counter/timer with gate, pulse output and event counting
// assumes an apb master on pclk and a neighbouring timer on the same clock
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "gect_regs.svh"

// Behaviour
// R1 - gate low holds count in timer mode
// R2 - direction bit enables gating in timer mode
// R3 - timer underflow inverts output pin
// R4 - output pin low while enable clear
// R5 - event source: pin edge or neighbour overflow
// R6 - event mode counts up or down by direction
// R7 - edge select picks rising, falling or both
// R8 - event underflow reloads or wraps to FFFFh
// R9 - event overflow reloads or wraps to 0000h
// R10 - event counting only while enabled
// R11 - re-enable resumes from held count
// R12 - after reset: reload down, zero up
// R13 - interrupt on every overflow or underflow
// R14 - event mode toggles output when enabled
// R15 - timer reset copies reload into counter
// R16 - count register reads live counter
// R17 - timer start needs enable, plus pin if gated
// R18 - timer counts down, interrupts on underflow
// R19 - 16-bit counter and reload, wrap limits
module gect_timer
  import gect_pkg::*;
#(
  parameter int CNT_W = `GECT_CNT_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_input_pin,
  input  wire logic        prev_overflow,
  output logic             timer_output_pin,
  output logic             overflow_out,
  output logic             irq
);
  import gect_pkg::*;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (CNT_W != `GECT_CNT_W) begin : g_bad_width
    $error("gect_timer supports a 16-bit counter only");
  end

  gect_state_t q;
  gect_state_t nx;
  logic        wr;
  logic        rd_setup;
  logic        pin_rise;
  logic        pin_fall;
  logic        prev_rise;
  logic        prev_fall;
  logic        ev;
  logic        tick;
  logic        up;
  logic        uf;
  logic        of;
  logic        trst;
  logic [1:0]  clr;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nx = q;
    // a write lands at the edge where the master sees pready
    wr = psel & penable & pwrite & q.pready;
    rd_setup = psel & penable & ~q.pready;
    clr = 2'h0;
    trst = 1'b0;
    pin_rise = 1'b0;
    pin_fall = 1'b0;
    // stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
    nx.pin_sync = {q.pin_sync[1:0], timer_input_pin};
    if (q.pin_sync[1] == q.pin_sync[2] && q.pin_sync[2] != q.pin_q) begin
      nx.pin_q = q.pin_sync[2];
      pin_rise = q.pin_sync[2];
      pin_fall = ~q.pin_sync[2];
    end
    nx.prev_q = prev_overflow;
    prev_rise = prev_overflow & ~q.prev_q;
    prev_fall = ~prev_overflow & q.prev_q;
    // see R5 see R7
    if (q.src) begin
      ev = (prev_rise & q.edge_sel[0]) | (prev_fall & q.edge_sel[1]);
    end else begin
      ev = (pin_rise & q.edge_sel[0]) | (pin_fall & q.edge_sel[1]);
    end
    // see R1 see R2 see R17 see R10 see R11
    tick = q.en & (q.mode ? ev : (~q.dir | q.pin_q));
    // see R6 see R18
    up = q.mode & q.dir;
    // see R19
    uf = tick & ~up & (q.cnt == `GECT_CNT_ZERO);
    of = tick & up & (q.cnt == `GECT_CNT_MAX);
    if (uf) begin
      nx.cnt = q.rld ? q.reload : `GECT_CNT_MAX; // see R8
    end else if (of) begin
      nx.cnt = q.rld ? q.reload : `GECT_CNT_ZERO; // see R9
    end else if (tick) begin
      nx.cnt = up ? q.cnt + 16'h0001 : q.cnt - 16'h0001;
    end
    nx.ovf = uf | of;
    if ((uf | of) & (~q.mode | q.outen)) begin
      nx.tout = ~q.tout; // see R3 see R14
    end
    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (wr) begin
      unique case (paddr)
        `GECT_CTRL_OFF: begin
          nx.en       = pwdata[`GECT_EN_B];
          nx.mode     = pwdata[`GECT_MODE_B];
          nx.dir      = pwdata[`GECT_DIR_B];
          nx.rld      = pwdata[`GECT_RLD_B];
          nx.outen    = pwdata[`GECT_OUTEN_B];
          nx.src      = pwdata[`GECT_SRC_B];
          nx.edge_sel = gect_edge_t'(pwdata[`GECT_EDGE_HI:`GECT_EDGE_LO]);
          trst        = pwdata[`GECT_TRST_B];
        end
        `GECT_RELOAD_OFF: nx.reload = pwdata[15:0];
        `GECT_CLR_OFF:    clr = pwdata[1:0];
        `GECT_INTEN_OFF:  nx.inten = pwdata[1:0];
        default: begin
        end
      endcase
    end
    // reset strobe wins over a count in the same cycle
    if (trst) begin
      nx.cnt = (nx.mode & nx.dir) ? `GECT_CNT_ZERO : q.reload; // see R12 see R15
    end
    if (!nx.en) begin
      nx.tout = 1'b0; // see R4
    end
    // set wins over clear
    nx.status = (q.status & ~clr) | {of, uf}; // see R13 see R18
    nx.irq = |(nx.status & nx.inten);
    // ----------------------------------------
    // apb answer: one wait state, unmapped flags pslverr
    // ----------------------------------------
    nx.pready = rd_setup;
    nx.pslverr = 1'b0;
    nx.prdata = 32'h0000_0000;
    if (rd_setup) begin
      unique case (paddr)
        `GECT_CTRL_OFF: begin
          nx.prdata[`GECT_EN_B]    = q.en;
          nx.prdata[`GECT_MODE_B]  = q.mode;
          nx.prdata[`GECT_DIR_B]   = q.dir;
          nx.prdata[`GECT_RLD_B]   = q.rld;
          nx.prdata[`GECT_OUTEN_B] = q.outen;
          nx.prdata[`GECT_SRC_B]   = q.src;
          nx.prdata[`GECT_EDGE_HI:`GECT_EDGE_LO] = q.edge_sel;
        end
        `GECT_RELOAD_OFF: nx.prdata[15:0] = q.reload;
        `GECT_COUNT_OFF:  nx.prdata[15:0] = q.cnt; // see R16
        `GECT_STATUS_OFF: nx.prdata[1:0] = q.status;
        `GECT_CLR_OFF:    nx.prdata = 32'h0000_0000;
        `GECT_INTEN_OFF:  nx.prdata[1:0] = q.inten;
        default:          nx.pslverr = 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.reload   <= `GECT_RELOAD_RST;
    end else begin
      q <= nx;
    end
  end

  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign timer_output_pin = q.tout;
  assign overflow_out     = q.ovf;
  assign irq              = q.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  gate_hold_a: assert property ( // see R1
    !q.mode && q.en && q.dir && !q.pin_q && !wr |=> q.cnt == $past(q.cnt))
    else $error("count moved while gate low");
  timer_dec_a: assert property ( // see R17
    !q.mode && q.en && !q.dir && q.cnt != 16'h0000 && !wr
      |=> q.cnt == $past(q.cnt) - 16'h0001)
    else $error("timer did not decrement");
  tout_toggle_a: assert property ( // see R3
    !q.mode && q.en && !q.dir && q.cnt == 16'h0000 && !wr
      |=> q.tout != $past(q.tout))
    else $error("output not inverted on underflow");
  tout_low_a: assert property (!q.en |-> !q.tout) // see R4
    else $error("output high while disabled");
  evt_reload_a: assert property ( // see R8
    q.mode && q.en && !q.dir && q.rld && ev && q.cnt == 16'h0000 && !wr
      |=> q.cnt == $past(q.reload))
    else $error("event underflow did not reload");
  evt_wrap_a: assert property ( // see R9
    q.mode && q.en && q.dir && !q.rld && ev && q.cnt == 16'hFFFF && !wr
      |=> q.cnt == 16'h0000)
    else $error("event overflow did not wrap");
  evt_stop_a: assert property ( // see R10
    q.mode && !q.en && !wr |=> $stable(q.cnt))
    else $error("event count moved while disabled");
  irq_raise_a: assert property ( // see R13
    (uf || of) && q.inten == 2'h3 && !wr |=> q.status != 2'h0 ##0 q.irq)
    else $error("wrap did not raise interrupt");
  reset_load_a: assert property ( // see R15
    trst && !(nx.mode && nx.dir) |=> q.cnt == $past(q.reload))
    else $error("timer reset did not load reload value");
  count_read_a: assert property ( // see R16
    rd_setup && paddr == `GECT_COUNT_OFF
      |=> pready && prdata[15:0] == $past(q.cnt))
    else $error("count read returned stale value");
  timer_wrap_a: assert property ( // see R18
    !q.mode && q.en && !q.dir && !q.rld && q.cnt == 16'h0000 && !wr |=> q.cnt == 16'hFFFF)
    else $error("timer underflow did not wrap");
  timer_reload_a: assert property ( // see R18
    !q.mode && q.en && !q.dir && q.rld && q.cnt == 16'h0000 && !wr |=> q.cnt == $past(q.reload))
    else $error("timer underflow did not reload");
  gate_run_a: assert property ( // see R1
    !q.mode && q.en && q.dir && q.pin_q && q.cnt != 16'h0000 && !wr |=> q.cnt == $past(q.cnt) - 16'h0001)
    else $error("gated timer did not count with pin high");
  timer_stop_a: assert property ( // see R17
    !q.mode && !q.en && !wr |=> $stable(q.cnt))
    else $error("timer count moved while disabled");
  evt_up_a: assert property ( // see R6
    q.mode && q.en && q.dir && ev && q.cnt != 16'hFFFF && !wr |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("event count did not increment");
  evt_down_a: assert property ( // see R6
    q.mode && q.en && !q.dir && ev && q.cnt != 16'h0000 && !wr |=> q.cnt == $past(q.cnt) - 16'h0001)
    else $error("event count did not decrement");
  evt_idle_a: assert property ( // see R5
    q.mode && !ev && !wr |=> $stable(q.cnt))
    else $error("event count moved without an event");
  evt_of_reload_a: assert property ( // see R9
    q.mode && q.en && q.dir && q.rld && ev && q.cnt == 16'hFFFF && !wr |=> q.cnt == $past(q.reload))
    else $error("event overflow did not reload");
  evt_uf_wrap_a: assert property ( // see R8
    q.mode && q.en && !q.dir && !q.rld && ev && q.cnt == 16'h0000 && !wr |=> q.cnt == 16'hFFFF)
    else $error("event underflow did not wrap");
  reset_up_a: assert property ( // see R12
    trst && nx.mode && nx.dir |=> q.cnt == 16'h0000)
    else $error("timer reset did not clear an up counter");
  evt_tout_a: assert property ( // see R14
    q.mode && q.en && !q.outen && !wr |=> $stable(q.tout))
    else $error("event output moved with output function off");
  tout_hold_a: assert property ( // see R3
    q.en && !uf && !of && !wr |=> $stable(q.tout))
    else $error("output moved without a wrap");
  edge_pick_a: assert property ( // see R7
    q.edge_sel == GECT_EDGE_NONE |-> !ev)
    else $error("event counted with no edge selected");
  src_pick_a: assert property ( // see R5
    q.src && !prev_rise && !prev_fall |-> !ev)
    else $error("pin edge counted with neighbour source");
  idle_hold_a: assert property ( // see R10
    !tick && !wr |=> $stable(q.cnt))
    else $error("count moved without a tick");
  pin_follow_a: assert property ( // see R1
    q.pin_sync[1] == q.pin_sync[2] |=> q.pin_q == $past(q.pin_sync[2]))
    else $error("settled pin level not taken");
  prev_track_a: assert property ( // see R5
    1'b1 |=> q.prev_q == $past(prev_overflow))
    else $error("neighbour overflow history lost");

  // ----------------------------------------
  // status, interrupt and bus checks
  // ----------------------------------------
  status_uf_a: assert property ( // see R13
    uf |=> q.status[0])
    else $error("underflow not recorded");
  status_of_a: assert property ( // see R13
    of |=> q.status[1])
    else $error("overflow not recorded");
  status_clear_a: assert property ( // see R13
    wr && paddr == `GECT_CLR_OFF && !uf && !of |=> (q.status & $past(pwdata[1:0])) == 2'h0)
    else $error("status bit not cleared");
  ovf_pulse_a: assert property ( // see R13
    (uf || of) |=> overflow_out)
    else $error("overflow output missed a wrap");
  ovf_quiet_a: assert property ( // see R13
    !(uf || of) |=> !overflow_out)
    else $error("overflow output without a wrap");
  irq_level_a: assert property ( // see R13
    irq == |(q.status & q.inten))
    else $error("interrupt level disagrees with status");
  reload_write_a: assert property ( // see R15
    wr && paddr == `GECT_RELOAD_OFF |=> q.reload == $past(pwdata[15:0]))
    else $error("reload write lost");
  inten_write_a: assert property ( // see R13
    wr && paddr == `GECT_INTEN_OFF |=> q.inten == $past(pwdata[1:0]))
    else $error("interrupt enable write lost");
  ctrl_write_a: assert property ( // see R10
    wr && paddr == `GECT_CTRL_OFF |=> q.en == $past(pwdata[`GECT_EN_B]))
    else $error("enable write lost");
  pready_pulse_a: assert property ( // see R16
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  pready_answer_a: assert property ( // see R16
    psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  prdata_idle_a: assert property ( // see R16
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data driven outside an answer");
  slverr_ready_a: assert property ( // see R16
    pslverr |-> pready)
    else $error("error flagged without pready");
  unmapped_err_a: assert property ( // see R16
    psel && penable && !pready && paddr == 12'h01C |=> pslverr)
    else $error("unmapped access not flagged");

  timer_uf_c: cover property (!q.mode && uf);
  event_uf_c: cover property (q.mode && uf);
  event_of_c: cover property (q.mode && of ##1 q.tout);
  gate_pause_c: cover property (!q.mode && q.en && q.dir && !q.pin_q [*3]);
  err_c: cover property (pslverr);

endmodule
`default_nettype wire

// ---- verification/gect_far_end.sv ----
// far side model: the timer input pin and the neighbouring timer's overflow
// assumes the bench drives pin_lvl and ovf_go just after rising pclk edges
`timescale 1ns/1ns
`default_nettype none
module gect_far_end (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_lvl,
  input  wire logic ovf_go,
  output var logic  timer_input_pin,
  output var logic  prev_overflow
);
  logic go_q;
  // neighbour overflow is one pclk wide, like a real timer's pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q            <= 1'b0;
      timer_input_pin <= 1'b0;
      prev_overflow   <= 1'b0;
    end else begin
      go_q            <= ovf_go;
      timer_input_pin <= pin_lvl;
      prev_overflow   <= ovf_go & ~go_q;
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_gated_event_counter_timer.sv ----
// self-checking bench of the gated counter/timer over apb
// assumes gect_regs.svh on the include path and gect_far_end on the pins
`timescale 1ns/1ns
`default_nettype none
`include "gect_regs.svh"
module test_gated_event_counter_timer;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, pin_lvl = 0, ovf_go = 0, tin, povf, tout, irq, err, ovo;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, ovo_cnt = 0;
  int          ctl[3] = '{32'h147, 32'h187, 32'h1C7};
  int          exp_e[3] = '{2, 2, 4};
  gect_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_pin(tin), .prev_overflow(povf),
    .timer_output_pin(tout), .overflow_out(ovo), .irq(irq));
  gect_far_end far (.pclk(pclk), .presetn(presetn), .pin_lvl(pin_lvl), .ovf_go(ovf_go),
    .timer_input_pin(tin), .prev_overflow(povf));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic finish_test;
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one wait state expected, but the master waits for pready whatever it takes
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(0, a, 0);
    chk(rd, exp);
  endtask
  // pulses on the pin, or neighbour overflows; waits out the pin synchroniser
  task automatic pulses(input logic ovf, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (ovf) ovf_go <= 1; else pin_lvl <= 1;
      repeat (4) @(posedge pclk);
      ovf_go <= 0; pin_lvl <= 0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask
  // ---------------------------------------------------------------
  // clock, timeout, sequence
  // ---------------------------------------------------------------
  initial forever #5 pclk = ~pclk;
  initial forever begin
    @(posedge pclk);
    cyc++;
    if (ovo === 1'b1) ovo_cnt++;
    if (cyc > 6000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rdchk(`GECT_RELOAD_OFF, 32'h0000FFFF);
    rdchk(`GECT_COUNT_OFF, 32'h00000000);
    xfer(0, 12'h01C, 0);
    chk({31'h0, err}, 32'h00000001);
    xfer(1, `GECT_INTEN_OFF, 32'h3);
    for (int i = 0; i < 3; i++) begin
      xfer(1, `GECT_CTRL_OFF, ctl[i]);
      pulses(0, 2);
      rdchk(`GECT_COUNT_OFF, exp_e[i]);
    end
    xfer(1, `GECT_CTRL_OFF, 32'h167);
    pulses(1, 3);
    rdchk(`GECT_COUNT_OFF, 32'h3);
    xfer(1, `GECT_CTRL_OFF, 32'h066);
    pulses(1, 2);
    rdchk(`GECT_COUNT_OFF, 32'h3);
    xfer(1, `GECT_CTRL_OFF, 32'h067);
    pulses(1, 1);
    rdchk(`GECT_COUNT_OFF, 32'h4);
    xfer(1, `GECT_CTRL_OFF, 32'h163);
    rdchk(`GECT_COUNT_OFF, 32'hFFFF);
    xfer(1, `GECT_CTRL_OFF, 32'h067);
    pulses(1, 1);
    rdchk(`GECT_COUNT_OFF, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdchk(`GECT_STATUS_OFF, 32'h2);
    xfer(1, `GECT_CLR_OFF, 32'h3);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    xfer(1, `GECT_RELOAD_OFF, 32'h1234);
    xfer(1, `GECT_CTRL_OFF, 32'h07B);
    pulses(1, 1);
    rdchk(`GECT_COUNT_OFF, 32'h1234);
    chk({31'h0, tout}, 32'h1);
    xfer(1, `GECT_RELOAD_OFF, 32'h0);
    xfer(1, `GECT_CTRL_OFF, 32'h173);
    pulses(1, 1);
    rdchk(`GECT_COUNT_OFF, 32'hFFFF);
    chk({31'h0, tout}, 32'h0);
    chk(ovo_cnt, 3);
    // timer mode, gated with the pin low: count must not move; then ungated it underflows and toggles the output, and disabling drives it low
    xfer(1, `GECT_RELOAD_OFF, 32'h5);
    xfer(1, `GECT_CTRL_OFF, 32'h10D);
    rdchk(`GECT_COUNT_OFF, 32'h5);
    rdchk(`GECT_COUNT_OFF, 32'h5);
    xfer(1, `GECT_CTRL_OFF, 32'h009);
    for (int i = 0; i < 20 && tout !== 1'b1; i++) @(negedge pclk);
    chk({31'h0, tout}, 32'h1);
    xfer(1, `GECT_CTRL_OFF, 32'h008);
    @(negedge pclk);
    chk({31'h0, tout}, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
